// ### logic/uiafc_pkg.sv
// Purpose: Shared constants for the serial interrupt and FIFO control block
// Assumes: Registers are one byte each in the low lane of a 32-bit word
// Notes:   Trigger tables are indexed by the two-bit field code
package uiafc_pkg;
	// Byte offsets on the register bus
	localparam int          ADDR_W   = 5;
	localparam logic [4:0]  OFS_MASK = 5'h00;
	localparam logic [4:0]  OFS_SRC  = 5'h04;
	localparam logic [4:0]  OFS_FIFO = 5'h08;
	localparam logic [4:0]  OFS_FEAT = 5'h0C;
	localparam logic [4:0]  OFS_ENH  = 5'h10;
	localparam logic [4:0]  OFS_TRIG = 5'h14;
	localparam logic [4:0]  OFS_LVL  = 5'h18;
	// Field positions of interrupt_mask_reg
	localparam int M_RX   = 0;
	localparam int M_TX   = 1;
	localparam int M_LS   = 2;
	localparam int M_MS   = 3;
	localparam int M_XOFF = 5;
	localparam int M_RTS  = 6;
	localparam int M_CTS  = 7;
	// Field positions of fifo_setup_reg
	localparam int F_EN    = 0;
	localparam int F_RXRST = 1;
	localparam int F_TXRST = 2;
	localparam int F_DMA   = 3;
	localparam int F_TXLO  = 4;
	localparam int F_RXLO  = 6;
	// Feature and enhanced fields
	localparam int         FT_TBLO  = 4;
	localparam int         FT_RS485 = 3;
	localparam int         FT_ROUTE = 7;
	localparam int         E_UNLOCK = 4;
	localparam logic [7:0] LCR_KEY  = 8'hBF;
	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [6:0] RST_LVL  = 7'h01;
	// Receive timeout: character times plus extra bit times
	localparam int CHAR_TIMES = 4;
	localparam int EXTRA_BITS = 12;
	// Trigger tables, index is the field code
	localparam logic [6:0] RX_A [4] = '{7'h01, 7'h04, 7'h08, 7'h0E};
	localparam logic [6:0] RX_B [4] = '{7'h08, 7'h10, 7'h18, 7'h1C};
	localparam logic [6:0] TX_B [4] = '{7'h10, 7'h08, 7'h18, 7'h1E};
	localparam logic [6:0] RX_C [4] = '{7'h08, 7'h10, 7'h38, 7'h3C};
	localparam logic [6:0] TX_C [4] = '{7'h08, 7'h10, 7'h20, 7'h38};
	// Interrupt source codes, bits 5:0
	typedef enum logic [5:0] {
		SRC_LS   = 6'b000110,
		SRC_RXTO = 6'b001100,
		SRC_RX   = 6'b000100,
		SRC_TX   = 6'b000010,
		SRC_MS   = 6'b000000,
		SRC_XOFF = 6'b010000,
		SRC_FLOW = 6'b100000,
		SRC_NONE = 6'b000001
	} uiafc_src_t;
endpackage

// ### logic/uiafc_top.sv
// Purpose: Interrupt ranking and FIFO setup for one serial channel
// Assumes: Status events and strobes come from logic on i_clk
// Notes:   Only the clear-to-send pin is synchronised here
// What this block does
// RL1 - Rising flow pins raise flagged interrupt
// RL2 - Source read shows one, holds until serviced
// RL3 - Line error bits raise line-status interrupt
// RL4 - Timeout after four chars plus twelve bits
// RL5 - Transmit ready on trigger, empty, or idle
// RL6 - Modem delta bits raise modem-status interrupt
// RL7 - Xoff or special match raises interrupt
// RL8 - Line read clears line; modem read clears modem and flow
// RL9 - Reads below trigger clear; holding read clears timeout
// RL10 - Source read or holding write clears transmit
// RL11 - Xoff cleared by Xon; special by next
// RL12 - Fixed six-bit code per priority level
// RL13 - Bit zero low means an interrupt pending
// RL14 - Bits five and four need enhanced unlock
// RL15 - Top two source bits mirror FIFO enable
// RL16 - Setup write only clears enable unless enable bit set
// RL17 - FIFO reset bits pulse and self clear
// RL18 - Setup bit three selects DMA pin mode
// RL19 - Transmit trigger writable only when unlocked
// RL20 - Receive trigger; last table applies both
// RL21 - Tables zero and one give fixed levels
// RL22 - Table two fixed, table three programmable
// RL23 - Table in feature bits, unlock behind key
//
// Register access over Avalon-MM and the register addresses were left to the implementer.
`timescale 1ns/1ps
module uiafc_top #(
	parameter int CHAR_BITS = 10
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic [4:0]  i_address,
	input  wire logic        i_read,
	input  wire logic        i_write,
	input  wire logic [31:0] i_writedata,
	input  wire logic [3:0]  i_byteenable,
	output logic      [31:0] o_readdata,
	output logic             o_waitrequest,
	input  wire logic [7:0]  i_line_ctrl,
	input  wire logic [6:0]  i_rx_count,
	input  wire logic [6:0]  i_tx_count,
	input  wire logic        i_tx_all_empty,
	input  wire logic        i_bit_tick,
	input  wire logic        i_ls_err,
	input  wire logic        i_msr_delta,
	input  wire logic        i_xoff_match,
	input  wire logic        i_xon_match,
	input  wire logic        i_special_match,
	input  wire logic        i_rx_char,
	input  wire logic        i_lsr_read,
	input  wire logic        i_msr_read,
	input  wire logic        i_rhr_read,
	input  wire logic        i_thr_write,
	input  wire logic        i_rts_n,
	input  wire logic        i_cts_n,
	output logic             o_int_pending,
	output logic             o_fifo_enable,
	output logic             o_dma_mode,
	output logic             o_rx_fifo_reset,
	output logic             o_tx_fifo_reset
);
	localparam logic [7:0] TMO_LIMIT = 8'(uiafc_pkg::CHAR_TIMES * CHAR_BITS
		+ uiafc_pkg::EXTRA_BITS);

	typedef struct packed {
		logic                  wait_n;
		logic [7:0]            rdata;
		logic [7:0]            mask;
		logic [7:0]            feat;
		logic [7:0]            enh;
		logic                  fifo_en;
		logic                  dma;
		logic [1:0]            rx_code;
		logic [1:0]            tx_code;
		logic [1:0]            table_sel;
		logic [6:0]            prog_rx;
		logic [6:0]            prog_tx;
		logic                  rx_rst;
		logic                  tx_rst;
		logic                  f_ls;
		logic                  f_to;
		logic                  f_tx;
		logic                  f_ms;
		logic                  f_xoff;
		logic                  f_spc;
		logic                  f_flow;
		logic                  over;
		uiafc_pkg::uiafc_src_t src;
		logic                  irq;
		logic [6:0]            rx_prev;
		logic [6:0]            tx_prev;
		logic                  empty_prev;
		logic                  mtx_prev;
		logic                  rts_prev;
		logic                  cts_s1;
		logic                  cts_s2;
		logic                  cts_prev;
		logic [7:0]            tmo;
	} uiafc_state_t;

	uiafc_state_t s;
	uiafc_state_t next_s;
	logic [6:0]   rx_lvl;
	logic [6:0]   tx_lvl;
	logic         unlocked;
	logic         req;
	logic         done;
	logic         rd_src;
	logic         ls_set, to_set, tx_set, ms_set;
	logic         xoff_set, spc_set, flow_set;
	logic         p_ls, p_to, p_rx, p_tx, p_ms, p_xs, p_fl;
	logic         cur_pend;
	logic         rx_hit;

	// Trigger levels from the table latched at the last setup write with enable set
	uiafc_trig u_trig (
		.i_table   (s.table_sel),
		.i_rx_code (s.rx_code),
		.i_tx_code (s.tx_code),
		.i_prog_rx (s.prog_rx),
		.i_prog_tx (s.prog_tx),
		.o_rx_lvl  (rx_lvl),
		.o_tx_lvl  (tx_lvl)
	);

	// Rising edge of a sampled level
	function automatic logic rose(input logic now, input logic prev);
		rose = now & ~prev;
	endfunction

	// Read value of a register; unmapped and write-only read zero
	function automatic logic [7:0] rd_val(input logic [4:0] a,
		input uiafc_state_t st, input logic [6:0] lr);
		case (a)
			uiafc_pkg::OFS_MASK: rd_val = st.mask;
			uiafc_pkg::OFS_SRC:  rd_val = {{2{st.fifo_en}}, st.src}; // RL15
			uiafc_pkg::OFS_FEAT: rd_val = st.feat;
			uiafc_pkg::OFS_ENH:  rd_val = st.enh;
			uiafc_pkg::OFS_TRIG: rd_val = {1'b0, st.feat[uiafc_pkg::FT_ROUTE]
				? st.prog_tx : st.prog_rx};
			uiafc_pkg::OFS_LVL:  rd_val = {1'b0, lr};
			default:             rd_val = uiafc_pkg::RST_BYTE;
		endcase
	endfunction

	// Bus handshake: one wait cycle, effects at the completing edge
	assign req    = i_read | i_write;
	assign done   = req & ~s.wait_n;
	assign rd_src = done & i_read & (i_address == uiafc_pkg::OFS_SRC);
	assign unlocked = s.enh[uiafc_pkg::E_UNLOCK];

	// Event detection feeding the sticky flags
	assign ls_set   = i_ls_err; // RL3
	assign ms_set   = i_msr_delta; // RL6
	assign xoff_set = i_xoff_match; // RL7
	assign spc_set  = i_special_match; // RL7
	assign flow_set = unlocked & // RL1
		((s.mask[uiafc_pkg::M_RTS] & rose(i_rts_n, s.rts_prev)) |
		(s.mask[uiafc_pkg::M_CTS] & rose(s.cts_s2, s.cts_prev)));
	assign to_set   = s.fifo_en & (i_rx_count != 7'h00) & // RL4
		(s.tmo == TMO_LIMIT) & ~s.f_to;
	// Trigger crossing, unfilled empty, idle line, or newly enabled
	always_comb begin
		if (s.feat[uiafc_pkg::FT_RS485]) begin
			tx_set = rose(i_tx_all_empty, s.empty_prev); // RL5
		end else if (s.fifo_en) begin
			tx_set = ((s.tx_prev >= tx_lvl) & (i_tx_count < tx_lvl)) | // RL5
				(~s.over & (s.tx_prev != 7'h00) & (i_tx_count == 7'h00));
		end else begin
			tx_set = (s.tx_prev != 7'h00) & (i_tx_count == 7'h00); // RL5
		end
		if (rose(s.mask[uiafc_pkg::M_TX], s.mtx_prev) && i_tx_count == 7'h00)
			tx_set = 1'b1;
	end

	// Pending sources after masking
	assign rx_hit = s.fifo_en ? (i_rx_count >= rx_lvl) // RL20
		: (i_rx_count != 7'h00);
	assign p_ls = s.f_ls & s.mask[uiafc_pkg::M_LS];
	assign p_to = s.f_to & s.mask[uiafc_pkg::M_RX];
	assign p_rx = rx_hit & s.mask[uiafc_pkg::M_RX]; // RL9
	assign p_tx = s.f_tx & s.mask[uiafc_pkg::M_TX];
	assign p_ms = s.f_ms & s.mask[uiafc_pkg::M_MS];
	assign p_xs = (s.f_xoff | s.f_spc) & s.mask[uiafc_pkg::M_XOFF]
		& unlocked; // RL14
	assign p_fl = s.f_flow & unlocked; // RL14

	// Whether the source now shown is still unserviced
	always_comb begin
		case (s.src)
			uiafc_pkg::SRC_LS:   cur_pend = p_ls;
			uiafc_pkg::SRC_RXTO: cur_pend = p_to;
			uiafc_pkg::SRC_RX:   cur_pend = p_rx;
			uiafc_pkg::SRC_TX:   cur_pend = p_tx;
			uiafc_pkg::SRC_MS:   cur_pend = p_ms;
			uiafc_pkg::SRC_XOFF: cur_pend = p_xs;
			uiafc_pkg::SRC_FLOW: cur_pend = p_fl;
			default:             cur_pend = 1'b0;
		endcase
	end

	// Next state of the whole block
	always_comb begin
		next_s            = s;
		next_s.rx_rst     = 1'b0; // RL17
		next_s.tx_rst     = 1'b0;
		next_s.wait_n     = ~(req & s.wait_n);
		next_s.cts_s1     = i_cts_n;
		next_s.cts_s2     = s.cts_s1;
		next_s.cts_prev   = s.cts_s2;
		next_s.rts_prev   = i_rts_n;
		next_s.rx_prev    = i_rx_count;
		next_s.tx_prev    = i_tx_count;
		next_s.empty_prev = i_tx_all_empty;
		next_s.mtx_prev   = s.mask[uiafc_pkg::M_TX];
		if (req && s.wait_n)
			next_s.rdata = rd_val(i_address, s, rx_lvl);
		// Register writes, low byte lane only
		if (done && i_write && i_byteenable[0]) begin
			case (i_address)
				uiafc_pkg::OFS_MASK: next_s.mask = i_writedata[7:0];
				uiafc_pkg::OFS_FEAT: next_s.feat = i_writedata[7:0];
				uiafc_pkg::OFS_ENH: begin
					if (i_line_ctrl == uiafc_pkg::LCR_KEY) // RL23
						next_s.enh = i_writedata[7:0];
				end
				uiafc_pkg::OFS_TRIG: begin
					if (s.feat[uiafc_pkg::FT_ROUTE]) // RL22
						next_s.prog_tx = i_writedata[6:0];
					else
						next_s.prog_rx = i_writedata[6:0];
				end
				uiafc_pkg::OFS_FIFO: begin
					next_s.fifo_en = i_writedata[uiafc_pkg::F_EN]; // RL16
					if (i_writedata[uiafc_pkg::F_EN]) begin
						next_s.rx_rst = i_writedata[uiafc_pkg::F_RXRST]; // RL17
						next_s.tx_rst = i_writedata[uiafc_pkg::F_TXRST];
						next_s.dma = i_writedata[uiafc_pkg::F_DMA]; // RL18
						next_s.rx_code = i_writedata[uiafc_pkg::F_RXLO +: 2];
						next_s.table_sel = s.feat[uiafc_pkg::FT_TBLO +: 2]; // RL20
						if (unlocked) // RL19
							next_s.tx_code = i_writedata[uiafc_pkg::F_TXLO +: 2];
					end
				end
				default: next_s.mask = s.mask;
			endcase
		end
		// Timeout timer restarts on each new or removed character
		if (i_rx_count == 7'h00 || i_rx_count != s.rx_prev || i_rhr_read)
			next_s.tmo = 8'h00;
		else if (i_bit_tick && s.tmo != TMO_LIMIT)
			next_s.tmo = 8'(s.tmo + 8'h01); // RL4
		// Track whether the last reload passed the transmit trigger
		if (i_tx_count > tx_lvl)
			next_s.over = 1'b1;
		else if (i_tx_count == 7'h00)
			next_s.over = 1'b0;
		// Sticky flags: a set in the clearing cycle wins
		next_s.f_ls = (s.f_ls & ~i_lsr_read) | ls_set; // RL8
		next_s.f_ms = (s.f_ms & ~i_msr_read) | ms_set; // RL8
		next_s.f_flow = (s.f_flow & ~i_msr_read) | flow_set; // RL8
		next_s.f_to = (s.f_to & ~i_rhr_read) | to_set; // RL9
		next_s.f_tx = (s.f_tx & ~(i_thr_write | // RL10
			(rd_src && s.src == uiafc_pkg::SRC_TX))) | tx_set;
		next_s.f_xoff = (s.f_xoff & ~(i_xon_match | // RL11
			(rd_src && s.src == uiafc_pkg::SRC_XOFF))) | xoff_set;
		next_s.f_spc = (s.f_spc & ~(i_rx_char | // RL11
			(rd_src && s.src == uiafc_pkg::SRC_XOFF))) | spc_set;
		// Shown source holds until serviced, then the highest wins
		if (!cur_pend) begin // RL2
			if (p_ls)
				next_s.src = uiafc_pkg::SRC_LS; // RL12
			else if (p_to)
				next_s.src = uiafc_pkg::SRC_RXTO;
			else if (p_rx)
				next_s.src = uiafc_pkg::SRC_RX;
			else if (p_tx)
				next_s.src = uiafc_pkg::SRC_TX;
			else if (p_ms)
				next_s.src = uiafc_pkg::SRC_MS;
			else if (p_xs)
				next_s.src = uiafc_pkg::SRC_XOFF;
			else if (p_fl)
				next_s.src = uiafc_pkg::SRC_FLOW;
			else
				next_s.src = uiafc_pkg::SRC_NONE;
		end
		next_s.irq = (next_s.src != uiafc_pkg::SRC_NONE); // RL13
	end

	// State register; reset takes constants only
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s           <= '0;
			s.wait_n    <= 1'b1;
			s.src       <= uiafc_pkg::SRC_NONE; // RL13
			s.prog_rx   <= uiafc_pkg::RST_LVL;
			s.prog_tx   <= uiafc_pkg::RST_LVL;
			s.cts_s1    <= 1'b1;
			s.cts_s2    <= 1'b1;
			s.cts_prev  <= 1'b1;
			s.rts_prev  <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from the state register
	assign o_readdata      = {24'h00_0000, s.rdata};
	assign o_waitrequest   = s.wait_n;
	assign o_int_pending   = s.irq;
	assign o_fifo_enable   = s.fifo_en;
	assign o_dma_mode      = s.dma;
	assign o_rx_fifo_reset = s.rx_rst;
	assign o_tx_fifo_reset = s.tx_rst;

	// Checks on the ranking and flag logic
	AST_FLOW_SET: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL1
		flow_set |=> s.f_flow) else $error("flow flag not set");
	AST_SRC_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL2
		cur_pend |=> $stable(s.src)) else $error("source changed early");
	AST_LS_SET: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL3
		i_ls_err ##1 s.mask[uiafc_pkg::M_LS] && s.src == uiafc_pkg::SRC_NONE
		|=> s.src == uiafc_pkg::SRC_LS) else $error("line status missed");
	AST_TMO: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL4
		$rose(s.f_to) |-> $past(s.tmo) == TMO_LIMIT)
		else $error("timeout at wrong count");
	AST_MS_SET: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL6
		i_msr_delta |=> s.f_ms) else $error("modem flag not set");
	AST_LS_CLR: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL8
		i_lsr_read && !i_ls_err |=> !s.f_ls) else $error("line not cleared");
	AST_TX_CLR: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL10
		i_thr_write && !tx_set |=> !s.f_tx) else $error("tx not cleared");
	AST_SPC_CLR: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL11
		i_rx_char && !i_special_match && !rd_src |=> !s.f_spc)
		else $error("special not cleared");
	AST_IDLE: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL13
		s.src == uiafc_pkg::SRC_NONE |-> !o_int_pending)
		else $error("pending while idle");
	AST_SRC_RD: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL15
		i_read && s.wait_n && i_address == uiafc_pkg::OFS_SRC
		|=> o_readdata[7:6] == {2{$past(s.fifo_en)}})
		else $error("fifo bits wrong");
	AST_IGNORE: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL16
		done && i_write && i_byteenable[0]
		&& i_address == uiafc_pkg::OFS_FIFO && !i_writedata[0]
		|=> !s.fifo_en && $stable(s.dma) && !s.rx_rst)
		else $error("setup not ignored");
	AST_RST_PULSE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_rx_fifo_reset |=> !o_rx_fifo_reset) // RL17
		else $error("reset not self clearing");
	AST_ACK: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		req && s.wait_n |=> !o_waitrequest ##1 o_waitrequest)
		else $error("bus answer timing");

	// Main scenarios
	COV_TMO: cover property (@(posedge i_clk) disable iff (!i_rst_n)
		s.src == uiafc_pkg::SRC_RXTO);
	COV_FLOW: cover property (@(posedge i_clk) disable iff (!i_rst_n)
		s.src == uiafc_pkg::SRC_FLOW);
	COV_TBL: cover property (@(posedge i_clk) disable iff (!i_rst_n)
		s.table_sel == 2'h3 && p_rx);
endmodule

// ### logic/uiafc_trig.sv
// Purpose: Trigger level lookup for receive and transmit FIFOs
// Assumes: Table select was latched at the last FIFO setup write with enable set
// Notes:   Purely combinational, inputs come from the caller's state register
`timescale 1ns/1ps
module uiafc_trig (
	input  wire logic [1:0] i_table,
	input  wire logic [1:0] i_rx_code,
	input  wire logic [1:0] i_tx_code,
	input  wire logic [6:0] i_prog_rx,
	input  wire logic [6:0] i_prog_tx,
	output logic      [6:0] o_rx_lvl,
	output logic      [6:0] o_tx_lvl
);
	// One table serves both directions
	always_comb begin
		case (i_table)
			2'h0: begin
				o_rx_lvl = uiafc_pkg::RX_A[i_rx_code]; // RL21
				o_tx_lvl = uiafc_pkg::RST_LVL;
			end
			2'h1: begin
				o_rx_lvl = uiafc_pkg::RX_B[i_rx_code]; // RL21
				o_tx_lvl = uiafc_pkg::TX_B[i_tx_code];
			end
			2'h2: begin
				o_rx_lvl = uiafc_pkg::RX_C[i_rx_code]; // RL22
				o_tx_lvl = uiafc_pkg::TX_C[i_tx_code];
			end
			default: begin
				o_rx_lvl = i_prog_rx; // RL22
				o_tx_lvl = i_prog_tx;
			end
		endcase
	end
endmodule

// ### verif/uiafc_bench.sv
// Purpose: Self-checking bench for interrupt ranking and FIFO setup
// Assumes: Timeout span shortened with one bit per character
// Notes:   Event inputs are one-cycle pulses driven on the rising edge
`timescale 1ns/1ps
module uiafc_bench;
	localparam logic [4:0] A_MASK = uiafc_pkg::OFS_MASK;
	localparam logic [4:0] A_SRC = uiafc_pkg::OFS_SRC;
	localparam logic [4:0] A_FIFO = uiafc_pkg::OFS_FIFO;
	localparam logic [4:0] A_FEAT = uiafc_pkg::OFS_FEAT;
	localparam logic [4:0] A_ENH = uiafc_pkg::OFS_ENH;
	localparam logic [4:0] A_TRIG = uiafc_pkg::OFS_TRIG;
	localparam logic [4:0] A_LVL = uiafc_pkg::OFS_LVL;
	localparam logic [10:0] E_LS = 11'h001, E_MS = 11'h002, E_XOFF = 11'h004;
	localparam logic [10:0] E_XON = 11'h008, E_SPC = 11'h010;
	localparam logic [10:0] E_CHR = 11'h020, E_LSR = 11'h040;
	localparam logic [10:0] E_MSR = 11'h080, E_RHR = 11'h100;
	localparam logic [10:0] E_THR = 11'h200, E_TICK = 11'h400;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [10:0] ev = 11'h000;
	logic [7:0]  lc = 8'h03;
	logic [6:0]  rxc = 7'h00;
	logic [6:0]  txc = 7'h00;
	logic        txe = 1'b1;
	logic        rts_n = 1'b0;
	logic        cts_n = 1'b0;
	logic [4:0]  addr;
	logic        rd_req;
	logic        wr_req;
	logic [31:0] wdata;
	logic [3:0]  be;
	logic [31:0] rdata;
	logic        wait_req;
	logic        int_p;
	logic        fifo_en;
	logic        dma;
	logic        rx_rst;
	logic        tx_rst;
	int          err_count = 0;
	int          samples_checked = 0;
	int          rx_pulses = 0;
	int          tx_pulses = 0;

	// 125 MHz clock
	always #4 clk = ~clk;

	uiafc_top #(.CHAR_BITS(1)) dut_u (
		.i_clk(clk), .i_rst_n(rst_n), .i_address(addr), .i_read(rd_req),
		.i_write(wr_req), .i_writedata(wdata), .i_byteenable(be),
		.o_readdata(rdata), .o_waitrequest(wait_req), .i_line_ctrl(lc),
		.i_rx_count(rxc), .i_tx_count(txc), .i_tx_all_empty(txe),
		.i_bit_tick(ev[10]), .i_ls_err(ev[0]), .i_msr_delta(ev[1]),
		.i_xoff_match(ev[2]), .i_xon_match(ev[3]), .i_special_match(ev[4]),
		.i_rx_char(ev[5]), .i_lsr_read(ev[6]), .i_msr_read(ev[7]),
		.i_rhr_read(ev[8]), .i_thr_write(ev[9]), .i_rts_n(rts_n),
		.i_cts_n(cts_n), .o_int_pending(int_p), .o_fifo_enable(fifo_en),
		.o_dma_mode(dma), .o_rx_fifo_reset(rx_rst), .o_tx_fifo_reset(tx_rst)
	);

	uiafc_host host_u (
		.i_clk(clk), .i_readdata(rdata), .i_waitrequest(wait_req),
		.o_address(addr), .o_read(rd_req), .o_write(wr_req),
		.o_writedata(wdata), .o_byteenable(be)
	);

	// Count reset pulse cycles away from the launching edge
	always @(negedge clk) begin
		rx_pulses += int'(rx_rst === 1'b1);
		tx_pulses += int'(tx_rst === 1'b1);
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [31:0] q;
		host_u.access(1'b0, a, {24'h00_0000, d}, 4'hF, q);
	endtask

	// Enhanced writes go out with the unlock key on the line control
	task automatic kwr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		lc <= uiafc_pkg::LCR_KEY;
		wr(a, d);
		lc <= 8'h03;
	endtask

	task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
		logic [31:0] q;
		host_u.access(1'b1, a, 32'h0000_0000, 4'hF, q);
		check(q, {24'h00_0000, e});
	endtask

	// One-cycle event pulse, then time for flag and code to settle
	task automatic pulse(input logic [10:0] m);
		@(posedge clk);
		ev <= m;
		@(posedge clk);
		ev <= 11'h000;
		repeat (3) @(posedge clk);
	endtask

	function automatic logic [7:0] sb(input uiafc_pkg::uiafc_src_t c);
		return {2'b11, c};
	endfunction

	task automatic complete_run;
		$display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Watchdog sized well above the full sequence
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		complete_run();
	end

	// Main sequence
	initial begin
		logic [6:0]  lv;
		logic [31:0] q;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		check(32'(int_p), 32'h0000_0000);
		rd_chk(A_SRC, 8'h01);
		rd_chk(A_MASK, uiafc_pkg::RST_BYTE);
		rd_chk(A_FEAT, uiafc_pkg::RST_BYTE);
		rd_chk(A_ENH, uiafc_pkg::RST_BYTE);
		rd_chk(A_TRIG, {1'b0, uiafc_pkg::RST_LVL});
		rd_chk(A_LVL, 8'h01);
		rd_chk(5'h1C, 8'h00);
		// Setup write without the enable bit changes nothing
		wr(A_FIFO, 8'h08);
		@(negedge clk);
		check(32'({fifo_en, dma}), 32'h0000_0000);
		wr(A_FIFO, 8'h09);
		@(negedge clk);
		check(32'({fifo_en, dma}), 32'h0000_0003);
		rd_chk(A_SRC, 8'hC1);
		rd_chk(A_FIFO, 8'h00);
		host_u.access(1'b0, A_MASK, 32'h0000_00FF, 4'hE, q);
		rd_chk(A_MASK, 8'h00);
		// Both FIFO resets pulse exactly once; disabled reset is ignored
		wr(A_FIFO, 8'h0F);
		wr(A_FIFO, 8'h06);
		@(negedge clk);
		check(32'(rx_pulses), 32'h0000_0001);
		check(32'(tx_pulses), 32'h0000_0001);
		check(32'(fifo_en), 32'h0000_0000);
		rd_chk(A_SRC, 8'h01);
		wr(A_FIFO, 8'h01);
		@(negedge clk);
		check(32'(dma), 32'h0000_0000);
		// Receive trigger for every table and field code
		for (int t = 0; t < 3; t++) begin
			for (int c = 0; c < 4; c++) begin
				lv = t == 0 ? uiafc_pkg::RX_A[c] :
					t == 1 ? uiafc_pkg::RX_B[c] : uiafc_pkg::RX_C[c];
				kwr(A_FEAT, 8'(t << 4));
				wr(A_FIFO, 8'(c << 6) | 8'h01);
				rd_chk(A_LVL, {1'b0, lv});
			end
		end
		kwr(A_FEAT, 8'h30);
		kwr(A_TRIG, 8'h25);
		wr(A_FIFO, 8'h01);
		rd_chk(A_TRIG, 8'h25);
		rd_chk(A_LVL, 8'h25);
		kwr(A_FEAT, 8'h00);
		wr(A_FIFO, 8'hC1);
		// Receive data level at fourteen, then timeout after 16 ticks
		wr(A_MASK, 8'h01);
		@(posedge clk);
		rxc <= 7'd14;
		repeat (3) @(posedge clk);
		rd_chk(A_SRC, sb(uiafc_pkg::SRC_RX));
		rxc <= 7'd13;
		repeat (3) @(posedge clk);
		rd_chk(A_SRC, 8'hC1);
		rxc <= 7'd2;
		repeat (15) pulse(E_TICK);
		rd_chk(A_SRC, 8'hC1);
		repeat (1) pulse(E_TICK);
		rd_chk(A_SRC, sb(uiafc_pkg::SRC_RXTO));
		pulse(E_RHR);
		rd_chk(A_SRC, 8'hC1);
		rxc <= 7'd0;
		// Transmit ready cleared by source read and by holding write
		wr(A_MASK, 8'h02);
		// Flag lands one edge after the mask, the code one edge later
		repeat (2) @(posedge clk);
		rd_chk(A_SRC, sb(uiafc_pkg::SRC_TX));
		rd_chk(A_SRC, 8'hC1);
		wr(A_MASK, 8'h00);
		wr(A_MASK, 8'h02);
		pulse(E_THR);
		rd_chk(A_SRC, 8'hC1);
		// Priority, and no preemption of a shown source
		wr(A_MASK, 8'h0C);
		pulse(E_LS | E_MS);
		@(negedge clk);
		check(32'(int_p), 32'h0000_0001);
		rd_chk(A_SRC, sb(uiafc_pkg::SRC_LS));
		pulse(E_LSR);
		rd_chk(A_SRC, sb(uiafc_pkg::SRC_MS));
		pulse(E_LS);
		rd_chk(A_SRC, sb(uiafc_pkg::SRC_MS));
		pulse(E_MSR);
		rd_chk(A_SRC, sb(uiafc_pkg::SRC_LS));
		pulse(E_LSR);
		rd_chk(A_SRC, 8'hC1);
		// Xoff ignored while locked, then raised and cleared
		wr(A_MASK, 8'h20);
		pulse(E_XOFF);
		rd_chk(A_SRC, 8'hC1);
		pulse(E_XON);
		kwr(A_ENH, 8'h10);
		wr(A_MASK, 8'h20);
		pulse(E_XOFF);
		@(negedge clk);
		check(32'(int_p), 32'h0000_0001);
		pulse(E_XON);
		@(negedge clk);
		check(32'(int_p), 32'h0000_0000);
		pulse(E_SPC);
		rd_chk(A_SRC, sb(uiafc_pkg::SRC_XOFF));
		rd_chk(A_SRC, 8'hC1);
		pulse(E_SPC);
		pulse(E_CHR);
		@(negedge clk);
		check(32'(int_p), 32'h0000_0000);
		// Rising flow-control pins raise, modem read clears
		wr(A_MASK, 8'hC0);
		for (int p = 0; p < 2; p++) begin
			@(posedge clk);
			if (p == 0)
				rts_n <= 1'b1;
			else
				cts_n <= 1'b1;
			repeat (6) @(posedge clk);
			rd_chk(A_SRC, sb(uiafc_pkg::SRC_FLOW));
			pulse(E_MSR);
			rd_chk(A_SRC, 8'hC1);
		end
		rts_n <= 1'b0;
		cts_n <= 1'b0;
		repeat (6) @(posedge clk);
		@(negedge clk);
		check(32'(int_p), 32'h0000_0000);
		// Transmit trigger of table one, code one, then RS-485 idle
		@(posedge clk);
		txc <= 7'd9;
		kwr(A_FEAT, 8'h10);
		wr(A_FIFO, 8'h11);
		wr(A_MASK, 8'h02);
		txc <= 7'd8;
		repeat (3) @(posedge clk);
		rd_chk(A_SRC, 8'hC1);
		txc <= 7'd7;
		repeat (3) @(posedge clk);
		rd_chk(A_SRC, sb(uiafc_pkg::SRC_TX));
		kwr(A_FEAT, 8'h08);
		txe <= 1'b0;
		repeat (3) @(posedge clk);
		rd_chk(A_SRC, 8'hC1);
		txe <= 1'b1;
		repeat (3) @(posedge clk);
		rd_chk(A_SRC, sb(uiafc_pkg::SRC_TX));
		complete_run();
	end
endmodule

// ### verif/uiafc_host.sv
// Purpose: Host processor model driving the register bus
// Assumes: Slave holds waitrequest high until it answers
// Notes:   Released write data is inverted so stale bytes never look valid
`timescale 1ns/1ps
module uiafc_host (
	input  wire logic        i_clk,
	input  wire logic [31:0] i_readdata,
	input  wire logic        i_waitrequest,
	output logic      [4:0]  o_address,
	output logic             o_read,
	output logic             o_write,
	output logic      [31:0] o_writedata,
	output logic      [3:0]  o_byteenable
);
	// Idle bus at time zero
	initial begin
		o_address = 5'h00;
		o_read = 1'b0;
		o_write = 1'b0;
		o_writedata = 32'h0000_0000;
		o_byteenable = 4'h0;
	end

	// One transfer; request stands until waitrequest is seen low.
	// Some setup writes from callers leave bit 0 clear while setting other bits
	// Transmit trigger field writes are only issued while unlocked
	task automatic access(input logic rd, input logic [4:0] a,
		input logic [31:0] d, input logic [3:0] be, output logic [31:0] q);
		@(posedge i_clk);
		o_address <= a;
		o_read <= rd;
		o_write <= !rd;
		o_writedata <= d;
		o_byteenable <= be;
		// Answer is taken at the rising edge that sees waitrequest low
		do @(posedge i_clk);
		while (i_waitrequest !== 1'b0);
		q = i_readdata;
		o_read <= 1'b0;
		o_write <= 1'b0;
		o_writedata <= ~d;
	endtask
endmodule
